/* File: intc_pkg.sv */
/*
 * intc_pkg: constants for the four-level interrupt controller.
 * assumes: an 8-bit special function register bus from the core.
 */
package intc_pkg;

    // ------------------------------------------------------------
    // sources and register map
    // ------------------------------------------------------------
    localparam int unsigned N_SRC  = 6;
    localparam int unsigned N_LVL  = 4;
    localparam logic [7:0] INTERRUPT_ENABLE_REG_ADDR = 8'ha8;
    localparam logic [7:0] PRIORITY_UPPER_REG_ADDR   = 8'hb7;
    localparam logic [7:0] PRIORITY_LOW_REG_ADDR     = 8'hb8;
    localparam logic [7:0] INTERRUPT_ENABLE_RST      = 8'h00;
    localparam logic [7:0] PRIORITY_RST              = 8'h00;

    // ------------------------------------------------------------
    // field positions, shared by enable and both priority registers
    // ------------------------------------------------------------
    localparam int unsigned EXT_LINE0_BIT      = 0;
    localparam int unsigned TIMER0_BIT         = 1;
    localparam int unsigned EXT_LINE1_BIT      = 2;
    localparam int unsigned TIMER1_BIT         = 3;
    localparam int unsigned UART_BIT           = 4;
    localparam int unsigned TIMER2_BIT         = 5;
    localparam int unsigned GLOBAL_INT_ENABLE_BIT = 7;
    localparam logic [7:0] ENABLE_IMPL_MASK    = 8'hbf;
    localparam logic [7:0] PRIORITY_IMPL_MASK  = 8'h3f;

    // ------------------------------------------------------------
    // vectors, indexed by polling rank (= bit position)
    // ------------------------------------------------------------
    localparam logic [7:0] VEC_EXT_LINE0 = 8'h03;
    localparam logic [7:0] VEC_TIMER0    = 8'h0b;
    localparam logic [7:0] VEC_EXT_LINE1 = 8'h13;
    localparam logic [7:0] VEC_TIMER1    = 8'h1b;
    localparam logic [7:0] VEC_UART      = 8'h23;
    localparam logic [7:0] VEC_TIMER2    = 8'h2b;

    typedef logic [1:0] level_t;
    typedef logic [2:0] src_idx_t;

endpackage : intc_pkg

/* File: irq_pick_if.sv */
/*
 * irq_pick_if: carries pending flags and settings to the priority picker
 * and the winner back.
 * assumes: both ends on the same clock; purely combinational path.
 */
`timescale 1ns/1ns
`default_nettype none
interface irq_pick_if;
    import intc_pkg::*;
    logic [N_SRC-1:0] pending;
    logic [7:0]       enable;
    logic [7:0]       prio_low;
    logic [7:0]       prio_upper;
    logic             win_valid;
    src_idx_t         win_idx;
    level_t           win_level;

    modport ctrl   (output pending, enable, prio_low, prio_upper,
                    input  win_valid, win_idx, win_level);
    modport picker (input  pending, enable, prio_low, prio_upper,
                    output win_valid, win_idx, win_level);
endinterface : irq_pick_if
`default_nettype wire

/* File: irq_picker.sv */
/*
 * irq_picker: picks the highest-level enabled pending source, ties broken
 * by polling rank.
 * assumes: inputs are stable registered values of the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module irq_picker
    import intc_pkg::*;
(
    irq_pick_if.picker pick
);

    // ------------------------------------------------------------
    // per-source eligibility and level
    // ------------------------------------------------------------
    logic [N_SRC-1:0] eligible;
    level_t           lvl [N_SRC];

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++)
        begin : g_src
            // reserved bit 6 never joins the and-term
            assign eligible[g] = pick.pending[g] & pick.enable[g]
                               & pick.enable[GLOBAL_INT_ENABLE_BIT];
            assign lvl[g]      = {pick.prio_upper[g], pick.prio_low[g]};
        end
    endgenerate

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    always_comb
    begin
        pick.win_valid = 1'b0;
        pick.win_idx   = '0;
        pick.win_level = '0;
        // ascending scan with strict compare keeps the lower rank on ties
        for (int i = 0; i < N_SRC; i++)
        begin
            if (eligible[i] && (!pick.win_valid || lvl[i] > pick.win_level))
            begin
                pick.win_valid = 1'b1;
                pick.win_idx   = src_idx_t'(i);
                pick.win_level = lvl[i];
            end
        end
    end

endmodule : irq_picker
`default_nettype wire

/* File: four_level_interrupt_ctrl.sv */
/*
 * four_level_interrupt_ctrl: six-source, four-level interrupt controller
 * with enable and two priority registers on the core's register bus.
 * assumes: flags come from peripherals on the same clock; the core pulses
 * i_int_ack for one cycle when it enters the vector and i_int_return when
 * it leaves a routine.
 */
`timescale 1ns/1ns
`default_nettype none
module four_level_interrupt_ctrl
    import intc_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    input  wire logic       i_ext_line0_flag,
    input  wire logic       i_ext_line0_edge_mode,
    input  wire logic       i_ext_line1_flag,
    input  wire logic       i_ext_line1_edge_mode,
    input  wire logic       i_timer0_overflow_flag,
    input  wire logic       i_timer1_overflow_flag,
    input  wire logic       i_timer2_overflow_flag,
    input  wire logic       i_timer2_external_flag,
    input  wire logic       i_uart_rx_flag,
    input  wire logic       i_uart_tx_flag,
    input  wire logic       i_int_ack,
    input  wire logic       i_int_return,
    output logic            o_int_req,
    output logic      [7:0] o_int_vector,
    output logic      [1:0] o_int_level,
    output logic      [3:0] o_in_service,
    output logic            o_ext_line0_clr,
    output logic            o_ext_line1_clr,
    output logic            o_timer0_overflow_clr,
    output logic            o_timer1_overflow_clr
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] vector_of(input src_idx_t idx);
        case (idx)
            3'd0:    vector_of = VEC_EXT_LINE0;
            3'd1:    vector_of = VEC_TIMER0;
            3'd2:    vector_of = VEC_EXT_LINE1;
            3'd3:    vector_of = VEC_TIMER1;
            3'd4:    vector_of = VEC_UART;
            default: vector_of = VEC_TIMER2;
        endcase
    endfunction : vector_of

    // index of highest set in-service level; valid flag in bit 2
    function automatic logic [2:0] top_level(input logic [3:0] ins);
        top_level = 3'b000;
        for (int i = 0; i < N_LVL; i++)
        begin
            if (ins[i])
            begin
                top_level = {1'b1, 2'(i)};
            end
        end
    endfunction : top_level

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] enable_q, enable_d;
    logic [7:0] prio_low_q, prio_low_d;
    logic [7:0] prio_upper_q, prio_upper_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        enable_d     = enable_q;
        prio_low_d   = prio_low_q;
        prio_upper_d = prio_upper_q;
        // reserved bits are not stored, so stray ones from software are harmless
        if (i_sfr_wr)
        begin
            case (i_sfr_addr)
                INTERRUPT_ENABLE_REG_ADDR: enable_d = i_sfr_wdata & ENABLE_IMPL_MASK;
                PRIORITY_UPPER_REG_ADDR:   prio_upper_d = i_sfr_wdata & PRIORITY_IMPL_MASK;
                PRIORITY_LOW_REG_ADDR:     prio_low_d = i_sfr_wdata & PRIORITY_IMPL_MASK;
                default:                   ;
            endcase
        end
        case (i_sfr_addr)
            INTERRUPT_ENABLE_REG_ADDR: rdata_d = enable_q;
            PRIORITY_UPPER_REG_ADDR:   rdata_d = prio_upper_q;
            PRIORITY_LOW_REG_ADDR:     rdata_d = prio_low_q;
            default:                   rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            enable_q     <= INTERRUPT_ENABLE_RST;
            prio_low_q   <= PRIORITY_RST;
            prio_upper_q <= PRIORITY_RST;
            rdata_q      <= 8'h00;
        end
        else
        begin
            enable_q     <= enable_d;
            prio_low_q   <= prio_low_d;
            prio_upper_q <= prio_upper_d;
            rdata_q      <= rdata_d;
        end
    end

    assign o_sfr_rdata = rdata_q;

    // ------------------------------------------------------------
    // request gathering and arbitration
    // ------------------------------------------------------------
    irq_pick_if pick_bus ();

    always_comb
    begin
        pick_bus.pending = '0;
        pick_bus.pending[EXT_LINE0_BIT] = i_ext_line0_flag;
        pick_bus.pending[TIMER0_BIT]    = i_timer0_overflow_flag;
        pick_bus.pending[EXT_LINE1_BIT] = i_ext_line1_flag;
        pick_bus.pending[TIMER1_BIT]    = i_timer1_overflow_flag;
        pick_bus.pending[UART_BIT]      = i_uart_rx_flag | i_uart_tx_flag;
        pick_bus.pending[TIMER2_BIT]    = i_timer2_overflow_flag | i_timer2_external_flag;
    end

    assign pick_bus.enable     = enable_q;
    assign pick_bus.prio_low   = prio_low_q;
    assign pick_bus.prio_upper = prio_upper_q;

    irq_picker u_picker (
        .pick (pick_bus.picker)
    );

    // ------------------------------------------------------------
    // service tracking and core handshake
    // ------------------------------------------------------------
    logic [3:0] in_service_q, in_service_d;
    logic       req_q, req_d;
    logic [7:0] vector_q, vector_d;
    level_t     level_q, level_d;
    src_idx_t   src_q, src_d;
    logic [3:0] clr_q, clr_d;
    logic [2:0] cur;
    logic       take;

    always_comb
    begin
        cur          = top_level(in_service_q);
        take         = i_int_ack & req_q;
        in_service_d = in_service_q;
        clr_d        = 4'b0000;
        // return first so a back-to-back ack in the same cycle still nests
        if (i_int_return && cur[2])
        begin
            in_service_d[cur[1:0]] = 1'b0;
        end
        if (take)
        begin
            in_service_d[level_q] = 1'b1;
            // level-mode external flags and uart/timer2 flags stay for software
            clr_d[0] = (src_q == src_idx_t'(EXT_LINE0_BIT)) & i_ext_line0_edge_mode;
            clr_d[1] = (src_q == src_idx_t'(EXT_LINE1_BIT)) & i_ext_line1_edge_mode;
            clr_d[2] = (src_q == src_idx_t'(TIMER0_BIT));
            clr_d[3] = (src_q == src_idx_t'(TIMER1_BIT));
        end
        // a request just taken is masked until its flag clear has landed
        req_d    = pick_bus.win_valid & ~take & (clr_q == 4'b0000)
                 & (!cur[2] || pick_bus.win_level > cur[1:0]);
        vector_d = vector_of(pick_bus.win_idx);
        level_d  = pick_bus.win_level;
        src_d    = pick_bus.win_idx;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            in_service_q <= 4'b0000;
            req_q        <= 1'b0;
            vector_q     <= 8'h00;
            level_q      <= '0;
            src_q        <= '0;
            clr_q        <= 4'b0000;
        end
        else
        begin
            in_service_q <= in_service_d;
            req_q        <= req_d;
            vector_q     <= vector_d;
            level_q      <= level_d;
            src_q        <= src_d;
            clr_q        <= clr_d;
        end
    end

    assign o_int_req             = req_q;
    assign o_int_vector          = vector_q;
    assign o_int_level           = level_q;
    assign o_in_service          = in_service_q;
    assign o_ext_line0_clr       = clr_q[0];
    assign o_ext_line1_clr       = clr_q[1];
    assign o_timer0_overflow_clr = clr_q[2];
    assign o_timer1_overflow_clr = clr_q[3];

endmodule : four_level_interrupt_ctrl
`default_nettype wire

/* File: intc_flag_owner.sv */
/* intc_flag_owner: peripheral flag owners at the far side of the controller.
   assumes: bench loads flag values; controller clear pulses on the same clock. */
`timescale 1ns/1ns
`default_nettype none
module intc_flag_owner
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_load,
    input  wire logic [7:0] i_load_val,
    input  wire logic [3:0] i_clr,
    output logic      [7:0] o_flags
);
    // ----
    // flags: ext0, t0, ext1, t1, rx, tx, t2 overflow, t2 external
    // ----
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    always_comb
    begin
        flags_d = i_load ? i_load_val : flags_q;
        flags_d[3:0] = flags_d[3:0] & ~i_clr;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst)
        if (!i_nrst) flags_q <= 8'h00;
        else flags_q <= flags_d;
    assign o_flags = flags_q;
endmodule : intc_flag_owner
`default_nettype wire

/* File: four_level_interrupt_ctrl_monitor.sv */
/* intc_monitor: port assertions for four_level_interrupt_ctrl.
   assumes: bound into the controller, one clock, async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module intc_monitor
    import intc_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_nrst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       i_ext_line0_edge_mode,
    input wire logic       i_ext_line1_edge_mode,
    input wire logic       i_int_ack,
    input wire logic       o_int_req,
    input wire logic [7:0] o_int_vector,
    input wire logic [1:0] o_int_level,
    input wire logic [3:0] o_in_service,
    input wire logic       o_ext_line0_clr,
    input wire logic       o_ext_line1_clr,
    input wire logic       o_timer0_overflow_clr,
    input wire logic       o_timer1_overflow_clr
);
    // ----
    // shadow of the enable register, reserved bit dropped
    // ----
    logic [7:0] en_q;
    logic [7:0] en_d;
    always_comb
    begin
        en_d = en_q;
        if (i_sfr_wr && i_sfr_addr == 8'ha8) en_d = i_sfr_wdata & 8'hbf;
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst)
        if (!i_nrst) en_q <= 8'h00;
        else en_q <= en_d;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    sequence acked(v);
        i_int_ack && o_int_req && o_int_vector == v;
    endsequence
    // clear pulse the cycle after its source was entered with mode set, and only then
    property clr_rule(clr, v, mode);
        (acked(v) ##0 mode |=> clr) and (clr |-> $past(o_int_req && i_int_ack
            && o_int_vector == v && mode));
    endproperty
    ext0_clear_a: assert property (clr_rule(o_ext_line0_clr, 8'h03, i_ext_line0_edge_mode))
        else $error("ext0 clear pulse wrong");
    ext1_clear_a: assert property (clr_rule(o_ext_line1_clr, 8'h13, i_ext_line1_edge_mode))
        else $error("ext1 clear pulse wrong");
    t0_clear_a: assert property (clr_rule(o_timer0_overflow_clr, 8'h0b, 1'b1))
        else $error("timer0 clear pulse wrong");
    t1_clear_a: assert property (clr_rule(o_timer1_overflow_clr, 8'h1b, 1'b1))
        else $error("timer1 clear pulse wrong");
    global_block_a: assert property (!$past(en_q[7]) |-> !o_int_req)
        else $error("request while globally disabled");
    // index by the vector now shown, not by the one shown a cycle earlier
    src_enable_a: assert property (o_int_req |-> (($past(en_q) >> o_int_vector[5:3]) & 8'h01) != 8'h00)
        else $error("request from disabled source");
    vector_set_a: assert property (o_int_req |-> o_int_vector inside {8'h03, 8'h0b, 8'h13,
        8'h1b, 8'h23, 8'h2b})
        else $error("vector outside table");
    ack_gap_a: assert property (i_int_ack && o_int_req |=> !o_int_req [*2])
        else $error("request too soon after entry");
    service_set_a: assert property (acked(o_int_vector) |=> o_in_service[$past(o_int_level)])
        else $error("entered level not in service");
    strict_preempt_a: assert property (o_int_req |-> (o_in_service >> o_int_level) == 4'h0)
        else $error("request not above service level");
    // read data shows the register as it stood when the address was sampled
    enable_read_a: assert property (i_sfr_addr == 8'ha8 |=> o_sfr_rdata == $past(en_q))
        else $error("enable readback wrong");
endmodule : intc_monitor
bind four_level_interrupt_ctrl intc_monitor mon (.i_sys_clk, .i_nrst, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_wdata, .o_sfr_rdata, .i_ext_line0_edge_mode, .i_ext_line1_edge_mode,
    .i_int_ack, .o_int_req, .o_int_vector, .o_int_level, .o_in_service, .o_ext_line0_clr,
    .o_ext_line1_clr, .o_timer0_overflow_clr, .o_timer1_overflow_clr);
`default_nettype wire

/* File: four_level_interrupt_ctrl_tb_top.sv */
/* four_level_interrupt_ctrl_tb_top: random self-checking bench of the controller.
   assumes: flag owner model drives the request flags; bench plays the core. */
`timescale 1ns/1ns
`default_nettype none
module four_level_interrupt_ctrl_tb_top;
    logic       i_sys_clk = 1'b0, i_nrst = 1'b0, i_sfr_wr = 1'b0, ld = 1'b0;
    logic       i_int_ack = 1'b0, i_int_return = 1'b0, o_int_req;
    logic       i_ext_line0_edge_mode = 1'b0, i_ext_line1_edge_mode = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, ldv = 8'h00;
    logic [7:0] o_sfr_rdata, o_int_vector, fl, en, lo, hi, f, fe;
    logic [1:0] o_int_level, em;
    logic [3:0] o_in_service, clr;
    logic [5:0] w, w2;
    int         failures = 0, n_tests = 0;
    integer     seed = 32'hd37ba428;
    always #5 i_sys_clk = ~i_sys_clk;
    four_level_interrupt_ctrl uut (.i_sys_clk, .i_nrst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
        .o_sfr_rdata, .i_ext_line0_flag(fl[0]), .i_ext_line0_edge_mode,
        .i_ext_line1_flag(fl[2]), .i_ext_line1_edge_mode, .i_timer0_overflow_flag(fl[1]),
        .i_timer1_overflow_flag(fl[3]), .i_timer2_overflow_flag(fl[6]),
        .i_timer2_external_flag(fl[7]), .i_uart_rx_flag(fl[4]), .i_uart_tx_flag(fl[5]),
        .i_int_ack, .i_int_return, .o_int_req, .o_int_vector, .o_int_level, .o_in_service,
        .o_ext_line0_clr(clr[0]), .o_ext_line1_clr(clr[2]),
        .o_timer0_overflow_clr(clr[1]), .o_timer1_overflow_clr(clr[3]));
    intc_flag_owner owner (.i_sys_clk, .i_nrst, .i_load(ld), .i_load_val(ldv), .i_clr(clr),
        .o_flags(fl));
    // ----
    // helpers
    // ----
    task automatic results;
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_sfr_addr <= a;
        i_sfr_wr <= 1'b1;
        i_sfr_wdata <= d;
        @(posedge i_sys_clk);
        i_sfr_wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_sfr_addr <= a;
        cyc(1);
        chk($sformatf("reg %h", a), e, o_sfr_rdata);
    endtask : rreg
    task automatic pulse(input logic ack, input logic load, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_int_ack <= ack;
        i_int_return <= !ack && !load;
        ld <= load;
        ldv <= v;
        @(posedge i_sys_clk);
        {i_int_ack, i_int_return, ld} <= 3'h0;
    endtask : pulse
    // winner: highest level, ties to lowest rank; {valid, level, index}
    function automatic logic [5:0] pick(input logic [7:0] fv, e, l, h);
        logic [5:0] p;
        logic [5:0] r;
        p = {fv[6] | fv[7], fv[4] | fv[5], fv[3:0]};
        r = 6'h00;
        for (int i = 0; i < 6; i++)
            if (e[7] && e[i] && p[i] && (!r[5] || {h[i], l[i]} > r[4:3]))
                r = {1'b1, h[i], l[i], i[2:0]};
        return r;
    endfunction : pick
    initial
    begin
        #100000;
        failures++;
        results();
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            f = (k == 0) ? 8'ha8 : (k == 1) ? 8'hb7 : 8'hb8;
            rreg(f, 8'h00);
            fe = $random(seed);
            wreg(f, fe);
            rreg(f, fe & ((k == 0) ? 8'hbf : 8'h3f));
        end
        wreg(8'ha9, 8'hff);
        rreg(8'ha9, 8'h00);
        for (int it = 0; it < 40; it++)
        begin
            en = (it == 0) ? 8'h3f : (it == 1) ? 8'hbf : $random(seed) & 8'hbf;
            lo = (it < 2) ? 8'h00 : $random(seed) & 8'h3f;
            hi = (it < 2) ? 8'h00 : $random(seed) & 8'h3f;
            f = (it < 2) ? 8'hff : $random(seed);
            em = $random(seed);
            wreg(8'ha8, en);
            wreg(8'hb7, hi);
            wreg(8'hb8, lo);
            {i_ext_line1_edge_mode, i_ext_line0_edge_mode} <= em;
            pulse(1'b0, 1'b1, f);
            cyc(3);
            w = pick(f, en, lo, hi);
            chk("req", 8'(w[5]), 8'(o_int_req));
            if (w[5])
            begin
                chk("vector", {2'b00, w[2:0], 3'b011}, o_int_vector);
                chk("level", 8'(w[4:3]), 8'(o_int_level));
                pulse(1'b1, 1'b0, 8'h00);
                fe = f & ~{4'h0, w[2:0] == 3, w[2:0] == 2 && em[1], w[2:0] == 1,
                    w[2:0] == 0 && em[0]};
                cyc(5);
                chk("flags", fe, fl);
                chk("in_service", 8'(4'h1 << w[4:3]), 8'(o_in_service));
                w2 = pick(fe, en, lo, hi);
                chk("preempt", 8'(w2[5] && w2[4:3] > w[4:3]), 8'(o_int_req));
                // every source raised while in service: only a strictly higher level may ask
                pulse(1'b0, 1'b1, 8'hff);
                cyc(3);
                w2 = pick(8'hff, en, lo, hi);
                chk("preempt_hi", 8'(w2[5] && w2[4:3] > w[4:3]), 8'(o_int_req));
                pulse(1'b0, 1'b0, 8'h00);
                cyc(2);
                chk("in_service", 8'h00, 8'(o_in_service));
            end
            pulse(1'b0, 1'b1, 8'h00);
        end
        results();
    end
endmodule : four_level_interrupt_ctrl_tb_top
`default_nettype wire
